// >>> hslp_port.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - four host bit rates, one active
// - jumper code zero gives 19.2 kbaud
// - frame: start, eight data, stop
// - rts/cts flow control both directions
// - raw binary octets, no ascii hex
// - two static jumpers select the rate
// - power-up sends status 91 12
// - then version report 92 04 version
// - header: type high nibble, count low
// - two 2 KB byte fifos
// - free-running 24-bit microsecond counter
// - tick 1 us, wrap after FFFFFF
module hslp_port #(
   parameter int unsigned       DEPTH      = hslp_pkg::FIFO_DEPTH,
   parameter logic [7:0]        FW_VERSION = hslp_pkg::FW_VERSION_DFLT
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic [1:0]               rate_select_jumpers,
   input  wire logic                     rxd,
   input  wire logic                     cts_n,
   output var  hslp_pkg::hslp_line_out_t line_out,
   input  wire hslp_pkg::hslp_byte_t     out_byte,
   output var  logic                     out_ready,
   output var  hslp_pkg::hslp_byte_t     in_byte,
   input  wire logic                     in_ready,
   output var  logic [23:0]              us_time
);
   import hslp_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] PTR_STEP = (AW+1)'(1);

   // microsecond counter
   logic [4:0]  us_div_ff;
   logic [23:0] us_ff;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         us_div_ff <= 5'h00;
         us_ff     <= US_RESET;
      end
      else if (us_div_ff == 5'(TICK_CYCLES - 1))
      begin
         us_div_ff <= 5'h00;
         us_ff     <= (us_ff == US_WRAP) ? US_RESET : us_ff + 24'h000001;
      end
      else
      begin
         us_div_ff <= us_div_ff + 5'h01;
      end
   end
   assign us_time = us_ff;

   // baud enable; jumpers are static straps, captured each cycle is harmless
   logic [7:0] div_sel;
   logic [7:0] baud_cnt_ff;
   logic       tick16_ff;
   always_comb
   begin
      unique case (rate_select_jumpers)
         RATE_19200:  div_sel = DIV_19200;
         RATE_38400:  div_sel = DIV_38400;
         RATE_57600:  div_sel = DIV_57600;
         RATE_115200: div_sel = DIV_115200;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (reset || baud_cnt_ff >= div_sel - 8'h01)
         baud_cnt_ff <= 8'h00;
      else
         baud_cnt_ff <= baud_cnt_ff + 8'h01;
      tick16_ff <= !reset && (baud_cnt_ff >= div_sel - 8'h01);
   end

   // fifo memories, each DEPTH bytes
   logic [7:0]  tx_mem [DEPTH];
   logic [7:0]  rx_mem [DEPTH];
   logic [AW:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
   logic [AW:0] tx_cnt, rx_cnt;
   assign tx_cnt = tx_wp_ff - tx_rp_ff;
   assign rx_cnt = rx_wp_ff - rx_rp_ff;

   // power-up report: 91 12 92 04 version
   logic [2:0] rep_idx_ff;
   logic [7:0] rep_byte;
   logic       rep_active;
   assign rep_active = rep_idx_ff != REPORT_LEN;
   always_comb
   begin
      unique case (rep_idx_ff)
         3'h0:    rep_byte = HDR_STATUS;  // type 9, one byte follows
         3'h1:    rep_byte = STATUS_IDLE;
         3'h2:    rep_byte = HDR_VERSION; // type 9, two bytes follow
         3'h3:    rep_byte = VERSION_SUBCODE;
         default: rep_byte = FW_VERSION;
      endcase
   end

   logic tx_full, tx_push;
   assign tx_full = tx_cnt == (AW+1)'(DEPTH);
   // report bytes go ahead of user traffic so the host sees them first
   assign tx_push = !tx_full && (rep_active || out_byte.valid);
   logic out_ready_ff;
   always_ff @(posedge clk)
      out_ready_ff <= !reset && !rep_active && (tx_cnt < (AW+1)'(DEPTH - 1));
   assign out_ready = out_ready_ff;
   // a byte offered while out_ready is low is neither stored nor counted
   logic tx_take;
   assign tx_take = tx_push && (rep_active || out_ready_ff);

   always_ff @(posedge clk)
   begin
      if (reset)
         rep_idx_ff <= 3'h0;
      else if (rep_active && !tx_full)
         rep_idx_ff <= rep_idx_ff + 3'h1;
   end

   logic tx_pop;
   always_ff @(posedge clk)
   begin
      if (tx_take)
         tx_mem[tx_wp_ff[AW-1:0]] <= rep_active ? rep_byte : out_byte.data;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         tx_wp_ff <= '0;
      else if (tx_take)
         tx_wp_ff <= tx_wp_ff + PTR_STEP;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         tx_rp_ff <= '0;
      else if (tx_pop)
         tx_rp_ff <= tx_rp_ff + PTR_STEP;
   end

   // transmitter
   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_LOAD  = 4'b0010,
      TX_ALIGN = 4'b0100,
      TX_SHIFT = 4'b1000
   } hslp_tx_state_t;
   hslp_tx_state_t tx_state_ff;
   logic [9:0]  tx_sh_ff;
   logic [3:0]  tx_bit_ff;
   logic [3:0]  tx_ph_ff;
   logic        txd_ff;
   logic        cts_q_ff;
   // cts only gates the start of a frame; one already on the line runs to its stop bit
   always_ff @(posedge clk)
      cts_q_ff <= reset ? 1'b1 : cts_n;
   assign tx_pop = (tx_state_ff == TX_IDLE) && (tx_cnt != '0) && !cts_q_ff;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff    <= 10'h3FF;
         tx_bit_ff   <= 4'h0;
         tx_ph_ff    <= 4'h0;
         txd_ff      <= 1'b1;
      end
      else
      begin
         unique case (tx_state_ff)
            TX_IDLE:
            begin
               txd_ff <= 1'b1;
               if (tx_pop)
                  tx_state_ff <= TX_LOAD;
            end
            TX_LOAD:
            begin
               tx_sh_ff    <= {1'b1, tx_mem[tx_rp_ff[AW-1:0] - AW'(1)], 1'b0};
               tx_bit_ff   <= 4'h0;
               tx_ph_ff    <= 4'h0;
               tx_state_ff <= TX_ALIGN;
            end
            // wait for a sample tick, else the start bit comes out short
            TX_ALIGN:
            begin
               if (tick16_ff)
                  tx_state_ff <= TX_SHIFT;
            end
            TX_SHIFT:
            begin
               txd_ff <= tx_sh_ff[0];
               if (tick16_ff)
               begin
                  tx_ph_ff <= tx_ph_ff + 4'h1;
                  if (tx_ph_ff == 4'(OVERSAMPLE - 1))
                  begin
                     tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
                     tx_bit_ff <= tx_bit_ff + 4'h1;
                     if (tx_bit_ff == 4'(DATA_BITS + 1)) // stop bit done
                        tx_state_ff <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // receiver; line taken as synchronous
   logic [3:0] rx_ph_ff;
   logic [3:0] rx_bit_ff;
   logic [7:0] rx_sh_ff;
   logic       rx_busy_ff;
   logic       rx_push_ff;
   logic       rx_full;
   assign rx_full = rx_cnt == (AW+1)'(DEPTH);
   always_ff @(posedge clk)
   begin
      rx_push_ff <= 1'b0;
      if (reset)
      begin
         rx_busy_ff <= 1'b0;
         rx_ph_ff   <= 4'h0;
         rx_bit_ff  <= 4'h0;
         rx_sh_ff   <= 8'h00;
      end
      else if (tick16_ff)
      begin
         if (!rx_busy_ff)
         begin
            rx_ph_ff  <= 4'h0;
            rx_bit_ff <= 4'h0;
            if (!rxd)
               rx_busy_ff <= 1'b1;
         end
         else
         begin
            rx_ph_ff <= rx_ph_ff + 4'h1;
            if (rx_ph_ff == 4'(OVERSAMPLE / 2 - 1))
            begin
               rx_bit_ff <= rx_bit_ff + 4'h1;
               if (rx_bit_ff == 4'h0 && rxd)
                  rx_busy_ff <= 1'b0; // glitch, not a start bit
               else if (rx_bit_ff == 4'(DATA_BITS + 1))
               begin
                  rx_busy_ff <= 1'b0;
                  rx_push_ff <= rxd && !rx_full; // framing error drops byte
               end
               else if (rx_bit_ff != 4'h0)
                  rx_sh_ff <= {rxd, rx_sh_ff[7:1]}; // lsb first
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rx_push_ff)
         rx_mem[rx_wp_ff[AW-1:0]] <= rx_sh_ff;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         rx_wp_ff <= '0;
      else if (rx_push_ff)
         rx_wp_ff <= rx_wp_ff + PTR_STEP;
   end

   // inbound output register, one byte held until accepted
   hslp_byte_t in_ff;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         in_ff    <= '0;
         rx_rp_ff <= '0;
      end
      else if (!in_ff.valid || in_ready)
      begin
         in_ff.valid <= rx_cnt != '0;
         in_ff.data  <= rx_mem[rx_rp_ff[AW-1:0]];
         if (rx_cnt != '0)
            rx_rp_ff <= rx_rp_ff + PTR_STEP;
      end
   end
   assign in_byte = in_ff;

   // margin covers bytes the host already has in flight when rts drops
   logic rts_n_ff;
   always_ff @(posedge clk)
      rts_n_ff <= reset ? 1'b1 : (rx_cnt >= (AW+1)'(DEPTH - RTS_MARGIN));

   assign line_out.txd   = txd_ff;
   assign line_out.rts_n = rts_n_ff;
endmodule // hslp_port
`default_nettype wire

// >>> hslp_pkg.sv
package hslp_pkg;

   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned TICK_NS         = 1000;
   // microsecond tick, rounded down so it never runs fast by more than a cycle
   localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000000) * TICK_NS / 1000;
   localparam int unsigned US_WIDTH        = 24;
   localparam logic [23:0] US_WRAP         = 24'hFFFFFF;
   localparam logic [23:0] US_RESET        = 24'h000000;

   localparam int unsigned BAUD_19200      = 19200;
   localparam int unsigned BAUD_38400      = 38400;
   localparam int unsigned BAUD_57600      = 57600;
   localparam int unsigned BAUD_115200     = 115200;
   localparam int unsigned OVERSAMPLE      = 16;
   // divider counts for the 16x sample enable, one per jumper code
   localparam logic [7:0] DIV_19200  = 8'((CLK_HZ + BAUD_19200 * 8) / (BAUD_19200 * 16));
   localparam logic [7:0] DIV_38400  = 8'((CLK_HZ + BAUD_38400 * 8) / (BAUD_38400 * 16));
   localparam logic [7:0] DIV_57600  = 8'((CLK_HZ + BAUD_57600 * 8) / (BAUD_57600 * 16));
   localparam logic [7:0] DIV_115200 = 8'((CLK_HZ + BAUD_115200 * 8) / (BAUD_115200 * 16));

   localparam logic [1:0] RATE_19200       = 2'h0;
   localparam logic [1:0] RATE_38400       = 2'h1;
   localparam logic [1:0] RATE_57600       = 2'h2;
   localparam logic [1:0] RATE_115200      = 2'h3;

   localparam int unsigned DATA_BITS       = 8;
   localparam int unsigned FIFO_DEPTH      = 2048;
   localparam int unsigned RTS_MARGIN      = 16;

   localparam logic [7:0] HDR_STATUS       = 8'h91;
   localparam logic [7:0] STATUS_IDLE      = 8'h12;
   localparam logic [7:0] HDR_VERSION      = 8'h92;
   localparam logic [7:0] VERSION_SUBCODE  = 8'h04;
   localparam logic [2:0] REPORT_LEN       = 3'h5;
   // arbitrary value
   localparam logic [7:0] FW_VERSION_DFLT  = 8'h01;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hslp_byte_t;

   typedef struct packed {
      logic       txd;
      logic       rts_n;
   } hslp_line_out_t;

endpackage

// >>> hslp_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module hslp_port_asserts (
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic [1:0]               rate_select_jumpers,
   input wire logic                     rxd,
   input wire logic                     cts_n,
   input wire hslp_pkg::hslp_line_out_t line_out,
   input wire hslp_pkg::hslp_byte_t     out_byte,
   input wire logic                     out_ready,
   input wire hslp_pkg::hslp_byte_t     in_byte,
   input wire logic                     in_ready,
   input wire logic [23:0]              us_time
);
   import hslp_pkg::*;
   logic [10:0] bit_len;
   logic [15:0] run_ff, cts_ff;
   logic [7:0]  gap_ff;
   logic [23:0] us_prev_ff;
   logic        txd_prev_ff, tseen_ff;
   always_comb
   begin
      case (rate_select_jumpers)
         RATE_19200: bit_len = {DIV_19200[6:0], 4'h0};
         RATE_38400: bit_len = {DIV_38400[6:0], 4'h0};
         RATE_57600: bit_len = {DIV_57600[6:0], 4'h0};
         default:    bit_len = {DIV_115200[6:0], 4'h0};
      endcase
   end
   // first tick after reset has no defined phase, so it is skipped
   always_ff @(posedge clk)
   begin
      us_prev_ff <= us_time;
      gap_ff <= (reset || us_time != us_prev_ff) ? 8'h0 : gap_ff + 8'h1;
      tseen_ff <= !reset && (tseen_ff || us_time != us_prev_ff);
   end
   always_ff @(posedge clk)
   begin
      txd_prev_ff <= line_out.txd;
      run_ff <= (reset || line_out.txd != txd_prev_ff) ? 16'h0 : run_ff + 16'h1;
      cts_ff <= !cts_n ? 16'h0 : cts_ff + {15'h0, cts_ff != 16'hFFFF};
   end
   sequence ready_low3;
      !out_ready [*3];
   endsequence
   reset_idle_a:
      assert property (@(posedge clk) reset |=> line_out.txd && line_out.rts_n
         && !in_byte.valid && !out_ready && us_time == US_RESET)
      else $error("outputs not idle after reset");
   report_wait_a:
      assert property (@(posedge clk) disable iff (reset) $fell(reset) |-> ready_low3)
      else $error("user bytes taken before report");
   us_step_a:
      assert property (@(posedge clk) disable iff (reset)
         $changed(us_time) |-> us_time == 24'($past(us_time) + 24'h1))
      else $error("time counter did not step by one");
   us_period_a:
      assert property (@(posedge clk) disable iff (reset)
         $changed(us_time) && tseen_ff |-> gap_ff == 8'(TICK_CYCLES - 1))
      else $error("time tick period wrong");
   bit_cell_a:
      assert property (@(posedge clk) disable iff (reset)
         $rose(line_out.txd) |-> ((run_ff + 16'h1) % bit_len) == 0)
      else $error("low run not whole bit cells");
   cts_gate_a:
      assert property (@(posedge clk) disable iff (reset)
         cts_ff > 16'(11 * bit_len) |-> line_out.txd)
      else $error("frame sent while clear to send withheld");
   in_hold_a:
      assert property (@(posedge clk) disable iff (reset) in_byte.valid && !in_ready
         |=> in_byte.valid && $stable(in_byte.data))
      else $error("received byte changed before taken");
   in_drop_a:
      assert property (@(posedge clk) disable iff (reset)
         $fell(in_byte.valid) |-> $past(in_ready))
      else $error("received byte dropped untaken");
endmodule // hslp_port_asserts
bind hslp_port hslp_port_asserts u_hslp_port_asserts (.clk(clk), .reset(reset),
   .rate_select_jumpers(rate_select_jumpers), .rxd(rxd), .cts_n(cts_n),
   .line_out(line_out), .out_byte(out_byte), .out_ready(out_ready),
   .in_byte(in_byte), .in_ready(in_ready), .us_time(us_time));
`default_nettype wire

// >>> hslp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hslp_host_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [10:0] bitc,
   input  wire logic        txd,
   input  wire logic        rts_n,
   input  wire logic        hold,
   output var  logic        rxd,
   output var  logic        cts_n
);
   logic [7:0] got[$];
   logic [9:0] f;
   logic       hit;
   int         sent = 0;
   initial rxd = 1'h1;
   assign cts_n = hold;
   task automatic send(input logic [7:0] b);
      logic [9:0] w;
      w = {1'h1, b, 1'h0};
      while (rts_n) @(negedge clk);
      for (int i = 0; i < 10; i++)
      begin
         rxd = w[i];
         repeat (bitc) @(negedge clk);
      end
      sent++;
   endtask
   task automatic wcyc(input int n);
      repeat (n)
      begin
         @(negedge clk);
         hit = hit | reset;
      end
   endtask
   // a frame cut by reset is abandoned so the next start bit is not missed
   always
   begin
      @(negedge txd);
      hit = 1'h0;
      wcyc(bitc / 2);
      for (int i = 0; i < 10; i++)
      begin
         f[i] = txd;
         if (i < 9 && !hit) wcyc(bitc);
      end
      if (!hit && f[9] && !f[0]) got.push_back(f[8:1]);
   end
endmodule // hslp_host_model
`default_nettype wire

// >>> hslp_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hslp_port_tb;
   import hslp_pkg::*;
   localparam logic [7:0] FW = 8'h5A; // arbitrary value
   logic           clk, reset, rxd, cts_n, out_ready, in_ready, hold, drain;
   logic [1:0]     rate_select_jumpers;
   hslp_line_out_t line_out;
   hslp_byte_t     out_byte, in_byte;
   logic [23:0]    us_time;
   logic [10:0]    bitc;
   logic [31:0]    seed;
   logic [7:0]     ob[$], ib[$], rq[$];
   int             err_count, comparisons, cyc, n;
   hslp_port #(.DEPTH(32), .FW_VERSION(FW)) u_hslp_port (.clk(clk), .reset(reset),
      .rate_select_jumpers(rate_select_jumpers), .rxd(rxd), .cts_n(cts_n),
      .line_out(line_out), .out_byte(out_byte), .out_ready(out_ready),
      .in_byte(in_byte), .in_ready(in_ready), .us_time(us_time));
   hslp_host_model u_hslp_host_model (.clk(clk), .reset(reset), .bitc(bitc),
      .txd(line_out.txd), .rts_n(line_out.rts_n), .hold(hold), .rxd(rxd), .cts_n(cts_n));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // 16 samples a bit at the rounded divider of each rate
   function automatic logic [10:0] bit_cycles(input logic [1:0] c);
      return c == 2'h0 ? 11'h410 : c == 2'h1 ? 11'h210 : c == 2'h2 ? 11'h160 : 11'h0B0;
   endfunction
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic start(input logic [1:0] c);
      reset = 1'h1;
      rate_select_jumpers = c;
      bitc = bit_cycles(c);
      repeat (6) @(negedge clk);
      reset = 1'h0;
      u_hslp_host_model.got.delete();
   endtask
   task automatic take(input logic [7:0] e);
      while (u_hslp_host_model.got.size() == 0) @(negedge clk);
      chk8("tx byte", e, u_hslp_host_model.got.pop_front());
   endtask
   task automatic put(input logic [7:0] b);
      out_byte = {1'h1, b};
      while (out_ready !== 1'h1) @(negedge clk);
      @(negedge clk);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         err_count++;
         close_out();
      end
   end
   always @(negedge clk)
   begin
      in_ready = drain & (rnd() > 8'h50);
      if (in_ready && in_byte.valid === 1'h1) rq.push_back(in_byte.data);
   end
   initial
   begin
      seed = 32'h12;
      {hold, drain} = 2'h0;
      out_byte = '0;
      err_count = 0;
      comparisons = 0;
      cyc = 0;
      // earlier rates are cut short by the next reset, mid-report
      for (int c = 0; c < 3; c++)
      begin
         start(2'(c));
         take(8'h91);
      end
      start(RATE_115200);
      ob = '{8'h91, 8'h12, 8'h92, 8'h04, FW};
      foreach (ob[i]) take(ob[i]);
      hold = 1'h1;
      ob = '{8'h00, 8'hFF, rnd(), rnd(), rnd()};
      foreach (ob[i]) put(ob[i]);
      out_byte.valid = 1'h0;
      n = int'(us_time);
      repeat (2000) @(negedge clk);
      chk8("us ticks", 8'h64, 8'(int'(us_time) - n));
      repeat (12 * bitc) @(negedge clk);
      chk8("sent while held", 8'h0, 8'(u_hslp_host_model.got.size()));
      hold = 1'h0;
      foreach (ob[i]) take(ob[i]);
      fork
         for (int i = 0; i < 18; i++)
         begin
            ib.push_back(i == 0 ? 8'hFF : rnd());
            u_hslp_host_model.send(ib[i]);
         end
      join_none
      while (line_out.rts_n !== 1'h1) @(negedge clk);
      repeat (20 * bitc) @(negedge clk);
      n = u_hslp_host_model.sent;
      repeat (10 * bitc) @(negedge clk);
      chk8("sent past rts", 8'(n), 8'(u_hslp_host_model.sent));
      chk8("rts level", 8'h1, {7'h0, line_out.rts_n});
      drain = 1'h1;
      while (rq.size() < 18) @(negedge clk);
      foreach (ib[i]) chk8("rx byte", ib[i], rq[i]);
      close_out();
   end
endmodule // hslp_port_tb
`default_nettype wire
